// *** src/scs_in_cond.sv ***
`timescale 1ns/1ns
module scs_in_cond (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Sync reset
  input wire logic pin_i, // Raw pin
  input wire logic pol_i, // 1: active at supply level
  output logic level_o, // Active level
  output logic edge_o // Pulse on either edge
);
  typedef struct packed {
    logic [2:0] sync;
    logic stable;
    logic evt;
  } scs_in_st_t;
  scs_in_st_t st;
  scs_in_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.sync = {st.sync[1:0], pin_i};
    next_st.evt = 1'b0;
    if (st.sync[1] == st.sync[2] && st.sync[2] != st.stable) begin
      next_st.stable = st.sync[2];
      next_st.evt = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_o = st.stable ~^ pol_i;
  assign edge_o = st.evt;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_edge_single: assert property (edge_o |=> !edge_o)
    else $error("input edge pulse longer than one cycle");
endmodule : scs_in_cond

// *** src/scs_pkg.sv ***
// -----------------------------------------------------------------
// What this block does
// - Off-delay 0 to 10000 ms, key adjusted
// - Output drop-out stretched by off-delay
// - Pulse set: off-delay refused, impulse notice
// - Held key gives growing step sizes
// - Pulse length 0 to 10000 ms
// - Pulse expiry forces output inactive
// - Own upper/lower thresholds per channel
// - Upper switch-on is value plus window
// - Upper release is upper plus hysteresis
// - Lower switch-on is value minus window, signed
// - Lower release is lower minus hysteresis
// - Only switch-on thresholds are writable
// - Six hue class thresholds in assignment
// - Host writes thresholds over serial link
// - Error pin keeps stage and polarity
// - Input pin: light off, trigger or teach
// - Per-input polarity selection
// - Trigger and teach start on any edge, light off follows the level
// - Normally-open asserts, normally-closed deasserts
// -----------------------------------------------------------------
package scs_pkg;
  localparam int CLK_NS = 4;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_NS;
  localparam int TW = 14;
  localparam logic [13:0] MAX_MS = 14'h2710;
  localparam logic [11:0] HOLD1_MS = 12'h1f4;
  localparam logic [11:0] HOLD2_MS = 12'h7d0;
  localparam logic [6:0] REPEAT_MS = 7'h64;
  localparam logic [13:0] STEP1 = 14'h0001;
  localparam logic [13:0] STEP2 = 14'h000a;
  localparam logic [13:0] STEP3 = 14'h0064;
  localparam int VW = 10;
  localparam int SW = 13;
  localparam int NCH = 8;
  localparam int NCLS = 6;
  localparam int NIN = 3;
  localparam int HYS_SHIFT = 2;
  localparam logic [2:0] HUE_CH = 3'h0;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_WIN = 8'h04;
  localparam logic [7:0] A_OND = 8'h08;
  localparam logic [7:0] A_OFFD = 8'h0c;
  localparam logic [7:0] A_PULSE = 8'h10;
  localparam logic [7:0] A_SEL = 8'h14;
  localparam logic [7:0] A_HON = 8'h18;
  localparam logic [7:0] A_LON = 8'h1c;
  localparam logic [7:0] A_HOFF = 8'h20;
  localparam logic [7:0] A_LOFF = 8'h24;
  localparam logic [7:0] A_ATHR = 8'h28;
  localparam logic [7:0] A_INCFG = 8'h2c;
  localparam logic [7:0] A_STAT = 8'h30;
  localparam logic [7:0] A_CMD = 8'h34;
  localparam int C_ASG = 0;
  localparam int C_NC = 1;
  localparam int C_SINK = 2;
  localparam int C_ENC = 3;
  localparam int C_ESINK = 4;
  localparam int C_CLS = 5;
  localparam int K_TEACH = 0;
  localparam int K_CLRN = 1;
  localparam logic [9:0] RST_WIN = 10'h020;
  localparam logic [8:0] RST_INCFG = 9'h000;
  typedef enum logic [1:0] {FN_NONE, FN_LIGHT, FN_TRIG, FN_TEACH} scs_fn_t;
  typedef enum logic [2:0] {
    TS_IDLE, TS_ONW, TS_HOLD, TS_OFFW, TS_PULSE, TS_PEND
  } scs_ts_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } scs_bus_t;
  typedef struct packed {
    logic valid;
    logic [2:0] ch;
    logic [9:0] val;
  } scs_meas_t;
  typedef struct packed {
    logic sink;
    logic source;
  } scs_stage_t;
endpackage : scs_pkg

// *** src/scs_step_adj.sv ***
`timescale 1ns/1ns
module scs_step_adj #(
  parameter int W = 14,
  parameter logic [W-1:0] MAX = scs_pkg::MAX_MS
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Sync reset
  input wire logic tick_i, // One-ms tick
  input wire logic inc_i, // Plus key level
  input wire logic dec_i, // Minus key level
  input wire logic sel_i, // Keys address this value
  input wire logic block_i, // Changes refused
  input wire logic load_i, // Software write
  input wire logic [W-1:0] load_val_i, // Software value
  output logic [W-1:0] value_o, // Current value
  output logic refused_o // Pulse on refused change
);
  typedef struct packed {
    logic [W-1:0] value;
    logic [11:0] held;
    logic [6:0] rep;
    logic pressed;
    logic refused;
  } scs_adj_st_t;
  scs_adj_st_t st;
  scs_adj_st_t next_st;

  localparam logic [11:0] HOLD2_LIM = scs_pkg::HOLD2_MS;

  always_comb begin
    logic press;
    logic act;
    logic [W:0] step;
    logic [W:0] sum;
    press = sel_i & (inc_i ^ dec_i);
    act = 1'b0;
    step = '0;
    sum = '0;
    next_st = st;
    next_st.refused = 1'b0;
    next_st.pressed = press;
    if (!press) begin
      next_st.held = '0;
      next_st.rep = '0;
    end else if (!st.pressed) begin
      act = 1'b1;
    end else if (tick_i) begin
      if (st.held != HOLD2_LIM) next_st.held = st.held + 12'h001;
      next_st.rep = st.rep + 7'h01;
      if (st.rep == scs_pkg::REPEAT_MS - 7'h01) begin
        act = 1'b1;
        next_st.rep = '0;
      end
    end
    // Longer hold, bigger jump
    if (st.held >= scs_pkg::HOLD2_MS) step = (W+1)'(scs_pkg::STEP3);
    else if (st.held >= scs_pkg::HOLD1_MS) step = (W+1)'(scs_pkg::STEP2);
    else step = (W+1)'(scs_pkg::STEP1);
    if (load_i) begin
      if (block_i) next_st.refused = 1'b1;
      else next_st.value = (load_val_i > MAX) ? MAX : load_val_i;
    end else if (act) begin
      if (block_i) begin
        next_st.refused = 1'b1;
      end else if (inc_i) begin
        sum = {1'b0, st.value} + step;
        next_st.value = (sum > {1'b0, MAX}) ? MAX : sum[W-1:0];
      end else begin
        next_st.value = ({1'b0, st.value} < step) ? '0 :
                        st.value - step[W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign value_o = st.value;
  assign refused_o = st.refused;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_value_range: assert property (value_o <= MAX)
    else $error("adjusted value above its maximum");
endmodule : scs_step_adj

// *** src/scs_switch_out.sv ***
`timescale 1ns/1ns
module scs_switch_out #(
  parameter int MS_CYCLES = scs_pkg::MS_CYCLES
) (
  input wire logic CLOCK_I, // 250 MHz clock
  input wire logic RESET_I, // Sync reset, high
  input wire scs_pkg::scs_bus_t BUS_I, // Register access
  output logic [31:0] RDATA_O, // Read data, cycle after read
  input wire scs_pkg::scs_meas_t MEAS_I, // Channel measurement
  input wire logic KEY_INC_I, // Plus key level
  input wire logic KEY_DEC_I, // Minus key level
  input wire logic KEY_SEL_I, // 0: off-delay, 1: pulse length
  input wire logic [2:0] IN_PIN_I, // Config inputs two/three/seven
  input wire logic ERROR_I, // Error or contamination event
  output scs_pkg::scs_stage_t SW_OUT_O, // Switch output one stage
  output scs_pkg::scs_stage_t ERR_OUT_O, // Error pin stage
  output logic LIGHT_OFF_O, // Emitted light shut down
  output logic IMPULSE_NOTE_O // Impulse notice on panel
);
  localparam int MW = $clog2(MS_CYCLES + 1);
  localparam int NCH = scs_pkg::NCH;
  localparam int SW = scs_pkg::SW;
  localparam int NCLS = scs_pkg::NCLS;
  localparam int NIN = scs_pkg::NIN;

  typedef struct packed {
    logic [MW-1:0] div;
    logic tick;
    logic [5:0] ctrl;
    logic [2:0] cls;
    logic [9:0] win;
    logic [13:0] ond;
    logic [2:0] sel;
    logic [NCH-1:0][SW-1:0] hon;
    logic [NCH-1:0][SW-1:0] lon;
    logic [NCLS-1:0][9:0] athr;
    logic [NIN-1:0][2:0] incfg;
    logic [NCH-1:0] inwin;
    logic [NCH-1:0] pend;
    logic asg_in;
    logic asg_pend;
    logic trig_cond;
    logic note;
    scs_pkg::scs_ts_t ts;
    logic [13:0] cnt;
    logic [31:0] rdata;
    scs_pkg::scs_stage_t sw_pin;
    scs_pkg::scs_stage_t err_pin;
    logic light;
  } scs_main_st_t;

  scs_main_st_t st;
  scs_main_st_t next_st;
  logic [NIN-1:0] in_lvl;
  logic [NIN-1:0] in_edge;
  logic [13:0] offd;
  logic [13:0] pulse;
  logic off_ref;
  logic pulse_ref;
  logic wr_offd;
  logic wr_pulse;

  // -----------------------------------------------------------------
  // Input pins and key adjusted timers
  // -----------------------------------------------------------------
  for (genvar i = 0; i < NIN; i++) begin : g_in
    scs_in_cond u_in (
      .clk_i(CLOCK_I),
      .rst_i(RESET_I),
      .pin_i(IN_PIN_I[i]),
      .pol_i(st.incfg[i][2]),
      .level_o(in_lvl[i]),
      .edge_o(in_edge[i])
    );
  end

  assign wr_offd = BUS_I.wr && BUS_I.addr == scs_pkg::A_OFFD;
  assign wr_pulse = BUS_I.wr && BUS_I.addr == scs_pkg::A_PULSE;

  scs_step_adj #(.W(14), .MAX(scs_pkg::MAX_MS)) u_offd (
    .clk_i(CLOCK_I),
    .rst_i(RESET_I),
    .tick_i(st.tick),
    .inc_i(KEY_INC_I),
    .dec_i(KEY_DEC_I),
    .sel_i(!KEY_SEL_I),
    .block_i(pulse != 14'h0000),
    .load_i(wr_offd),
    .load_val_i(BUS_I.wdata[13:0]),
    .value_o(offd),
    .refused_o(off_ref)
  );

  scs_step_adj #(.W(14), .MAX(scs_pkg::MAX_MS)) u_pulse (
    .clk_i(CLOCK_I),
    .rst_i(RESET_I),
    .tick_i(st.tick),
    .inc_i(KEY_INC_I),
    .dec_i(KEY_DEC_I),
    .sel_i(KEY_SEL_I),
    .block_i(1'b0),
    .load_i(wr_pulse),
    .load_val_i(BUS_I.wdata[13:0]),
    .value_o(pulse),
    .refused_o(pulse_ref)
  );

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  always_comb begin
    logic signed [SW-1:0] v;
    logic signed [SW-1:0] hys;
    logic signed [SW-1:0] hoff;
    logic signed [SW-1:0] loff;
    logic signed [SW-1:0] ad;
    logic [2:0] c;
    logic trig_mode;
    logic teach;
    logic cond;
    logic done;
    logic [13:0] eff_off;
    logic act;
    v = $signed({{(SW-scs_pkg::VW){1'b0}}, MEAS_I.val});
    hys = $signed({{(SW-scs_pkg::VW){1'b0}},
                   st.win >> scs_pkg::HYS_SHIFT});
    c = MEAS_I.ch;
    hoff = $signed(st.hon[c]) + hys;
    loff = $signed(st.lon[c]) - hys;
    ad = '0;
    trig_mode = 1'b0;
    teach = 1'b0;
    cond = 1'b0;
    done = 1'b0;
    eff_off = '0;
    act = 1'b0;
    next_st = st;

    // Millisecond tick
    next_st.tick = 1'b0;
    if (st.div == MW'(MS_CYCLES - 1)) begin
      next_st.div = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.div = st.div + MW'(1);
    end

    // Input functions
    next_st.light = 1'b0;
    for (int i = 0; i < NIN; i++) begin
      if (st.incfg[i][1:0] == scs_pkg::FN_LIGHT && in_lvl[i])
        next_st.light = 1'b1;
      if (st.incfg[i][1:0] == scs_pkg::FN_TRIG) trig_mode = 1'b1;
      if (st.incfg[i][1:0] == scs_pkg::FN_TEACH && in_edge[i])
        teach = 1'b1;
    end

    // Register writes; release thresholds are never stored
    if (BUS_I.wr) begin
      case (BUS_I.addr)
        scs_pkg::A_CTRL: begin
          next_st.ctrl = BUS_I.wdata[5:0];
          next_st.cls = BUS_I.wdata[scs_pkg::C_CLS +: 3];
        end
        scs_pkg::A_WIN: next_st.win = BUS_I.wdata[9:0];
        scs_pkg::A_OND: next_st.ond = (BUS_I.wdata[13:0] >
          scs_pkg::MAX_MS) ? scs_pkg::MAX_MS : BUS_I.wdata[13:0];
        scs_pkg::A_SEL: next_st.sel = BUS_I.wdata[2:0];
        scs_pkg::A_HON: next_st.hon[st.sel] = BUS_I.wdata[SW-1:0];
        scs_pkg::A_LON: next_st.lon[st.sel] = BUS_I.wdata[SW-1:0];
        scs_pkg::A_ATHR:
          if (st.sel < 3'(NCLS)) next_st.athr[st.sel] = BUS_I.wdata[9:0];
        scs_pkg::A_INCFG: next_st.incfg = BUS_I.wdata[8:0];
        scs_pkg::A_CMD: teach = teach | BUS_I.wdata[scs_pkg::K_TEACH];
        default: ;
      endcase
    end

    // Impulse notice, a refusal wins over a clear
    next_st.note = (st.note & !(BUS_I.wr && BUS_I.addr == scs_pkg::A_CMD &&
                    BUS_I.wdata[scs_pkg::K_CLRN])) | off_ref;

    if (teach) begin
      if (st.ctrl[scs_pkg::C_ASG]) next_st.asg_pend = 1'b1;
      else next_st.pend = '1;
    end

    // Measurement: teach and window tracking
    if (MEAS_I.valid) begin
      if (st.pend[c]) begin
        next_st.pend[c] = 1'b0;
        next_st.hon[c] = v + $signed({3'h0, st.win});
        next_st.lon[c] = v - $signed({3'h0, st.win});
      end
      if (v >= $signed(st.lon[c]) && v <= $signed(st.hon[c]))
        next_st.inwin[c] = 1'b1;
      else if (v > hoff || v < loff)
        next_st.inwin[c] = 1'b0;
      if (c == scs_pkg::HUE_CH) begin
        if (st.asg_pend) begin
          next_st.asg_pend = 1'b0;
          next_st.athr[st.cls] = MEAS_I.val;
        end
        ad = v - $signed({3'h0, st.athr[st.cls]});
        if (ad < 0) ad = -ad;
        if (ad <= $signed({3'h0, st.win})) next_st.asg_in = 1'b1;
        else if (ad > $signed({3'h0, st.win}) + hys)
          next_st.asg_in = 1'b0;
      end
    end

    cond = st.ctrl[scs_pkg::C_ASG] ? st.asg_in : &st.inwin;
    for (int i = 0; i < NIN; i++) begin
      if (st.incfg[i][1:0] == scs_pkg::FN_TRIG && in_edge[i])
        next_st.trig_cond = cond;
    end
    if (trig_mode) cond = st.trig_cond;

    // Output timing
    eff_off = (pulse != 14'h0000) ? 14'h0000 : offd;
    if (st.tick) next_st.cnt = st.cnt + 14'h0001;
    case (st.ts)
      scs_pkg::TS_IDLE: begin
        next_st.cnt = '0;
        if (cond && st.ond != 14'h0000) next_st.ts = scs_pkg::TS_ONW;
        else if (cond) done = 1'b1;
      end
      scs_pkg::TS_ONW: begin
        if (!cond) next_st.ts = scs_pkg::TS_IDLE;
        else if (st.tick && st.cnt + 14'h0001 >= st.ond) done = 1'b1;
      end
      scs_pkg::TS_HOLD: begin
        next_st.cnt = '0;
        if (!cond && eff_off != 14'h0000)
          next_st.ts = scs_pkg::TS_OFFW;
        else if (!cond) next_st.ts = scs_pkg::TS_IDLE;
      end
      scs_pkg::TS_OFFW: begin
        if (cond) next_st.ts = scs_pkg::TS_HOLD;
        else if (st.tick && st.cnt + 14'h0001 >= eff_off)
          next_st.ts = scs_pkg::TS_IDLE;
      end
      scs_pkg::TS_PULSE: begin
        if (st.tick && st.cnt + 14'h0001 >= pulse)
          next_st.ts = scs_pkg::TS_PEND;
      end
      scs_pkg::TS_PEND: begin
        if (!cond) next_st.ts = scs_pkg::TS_IDLE;
      end
      default: next_st.ts = scs_pkg::TS_IDLE;
    endcase
    if (done) begin
      next_st.cnt = '0;
      next_st.ts = (pulse != 14'h0000) ? scs_pkg::TS_PULSE :
                   scs_pkg::TS_HOLD;
    end

    // Pins
    act = next_st.ts == scs_pkg::TS_HOLD || next_st.ts == scs_pkg::TS_OFFW ||
          next_st.ts == scs_pkg::TS_PULSE;
    act = act ^ st.ctrl[scs_pkg::C_NC];
    next_st.sw_pin.sink = act & st.ctrl[scs_pkg::C_SINK];
    next_st.sw_pin.source = act & !st.ctrl[scs_pkg::C_SINK];
    act = ERROR_I ^ st.ctrl[scs_pkg::C_ENC];
    next_st.err_pin.sink = act & st.ctrl[scs_pkg::C_ESINK];
    next_st.err_pin.source = act & !st.ctrl[scs_pkg::C_ESINK];

    // Read data, valid one cycle after the strobe
    next_st.rdata = '0;
    if (BUS_I.rd) begin
      case (BUS_I.addr)
        scs_pkg::A_CTRL: next_st.rdata = {24'h0, st.cls, st.ctrl[4:0]};
        scs_pkg::A_WIN: next_st.rdata = {22'h0, st.win};
        scs_pkg::A_OND: next_st.rdata = {18'h0, st.ond};
        scs_pkg::A_OFFD: next_st.rdata = {18'h0, offd};
        scs_pkg::A_PULSE: next_st.rdata = {18'h0, pulse};
        scs_pkg::A_SEL: next_st.rdata = {29'h0, st.sel};
        scs_pkg::A_HON: next_st.rdata = 32'(signed'(st.hon[st.sel]));
        scs_pkg::A_LON: next_st.rdata = 32'(signed'(st.lon[st.sel]));
        scs_pkg::A_HOFF: next_st.rdata =
          32'($signed(st.hon[st.sel]) + hys);
        scs_pkg::A_LOFF: next_st.rdata =
          32'($signed(st.lon[st.sel]) - hys);
        scs_pkg::A_ATHR: if (st.sel < 3'(NCLS))
          next_st.rdata = {22'h0, st.athr[st.sel]};
        scs_pkg::A_INCFG: next_st.rdata = {23'h0, st.incfg};
        scs_pkg::A_STAT: next_st.rdata = {24'h0, st.ts, in_lvl,
          st.note, st.light};
        default: next_st.rdata = '0;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      st <= '0;
      st.win <= scs_pkg::RST_WIN;
      st.incfg <= scs_pkg::RST_INCFG;
      st.ts <= scs_pkg::TS_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign RDATA_O = st.rdata;
  assign SW_OUT_O = st.sw_pin;
  assign ERR_OUT_O = st.err_pin;
  assign LIGHT_OFF_O = st.light;
  assign IMPULSE_NOTE_O = st.note;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);

  sequence s_off_refused;
    wr_offd && pulse != 14'h0000;
  endsequence
  sequence s_pulse_expire;
    st.ts == scs_pkg::TS_PULSE && st.tick && st.cnt + 14'h0001 >= pulse;
  endsequence

  a_off_kept: assert property (s_off_refused |=> $stable(offd))
    else $error("off-delay changed while pulse set");
  a_notice_set: assert property (s_off_refused |-> ##2 IMPULSE_NOTE_O)
    else $error("impulse notice missing");
  a_pulse_end: assert property (s_pulse_expire |=>
    st.ts == scs_pkg::TS_PEND ##1 (SW_OUT_O ==
    ({2{st.ctrl[scs_pkg::C_NC]}} & {st.ctrl[scs_pkg::C_SINK],
    !st.ctrl[scs_pkg::C_SINK]}) || st.ts != scs_pkg::TS_PEND))
    else $error("pulse did not end");
  a_off_stretch: assert property (st.ts == scs_pkg::TS_OFFW &&
    pulse == 14'h0000 && !(st.tick && st.cnt + 14'h0001 >= offd)
    |=> st.ts != scs_pkg::TS_IDLE)
    else $error("off-delay cut short");
  a_on_pulse: assert property (st.ts == scs_pkg::TS_ONW && st.tick &&
    st.cnt + 14'h0001 >= st.ond && pulse != 14'h0000 && $stable(pulse)
    |=> st.ts == scs_pkg::TS_PULSE && st.cnt == 14'h0000)
    else $error("pulse did not follow on-delay");
  a_teach_high: assert property (MEAS_I.valid && st.pend[MEAS_I.ch]
    |=> $signed(st.hon[$past(MEAS_I.ch)]) ==
    $signed({3'h0, $past(MEAS_I.val)}) + $signed({3'h0, st.win}))
    else $error("upper switch-on threshold wrong");
  a_teach_low: assert property (MEAS_I.valid && st.pend[MEAS_I.ch]
    |=> $signed(st.lon[$past(MEAS_I.ch)]) ==
    $signed({3'h0, $past(MEAS_I.val)}) - $signed({3'h0, st.win}))
    else $error("lower switch-on threshold wrong");
  a_window_in: assert property (MEAS_I.valid && !st.pend[MEAS_I.ch] &&
    $signed({3'h0, MEAS_I.val}) >= $signed(st.lon[MEAS_I.ch]) &&
    $signed({3'h0, MEAS_I.val}) <= $signed(st.hon[MEAS_I.ch])
    |=> st.inwin[$past(MEAS_I.ch)])
    else $error("value in window not detected");
endmodule : scs_switch_out

// *** verification/scs_load_model.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// Load wired to switch output one
// ----------------------------------------
module scs_load_model (
  input wire logic clk_i, // Clock
  input wire scs_pkg::scs_stage_t stage_i, // Output stage drive
  output logic on_o, // Load energised
  output int len_o // Cycles of last on period
);
  int run = 0;
  // Either stage conducting energises the load
  assign on_o = stage_i.sink | stage_i.source;
  always @(posedge clk_i) begin
    run <= on_o ? run + 1 : 0;
    if (!on_o && run != 0) begin
      len_o <= run;
    end
  end
endmodule : scs_load_model

// *** verification/scs_switch_out_bench.sv ***
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  miscompares++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module scs_switch_out_bench;
  logic clk, rst, inc, dec, ksel, err, light, note, on;
  logic [2:0] pins;
  logic [31:0] rdata, v;
  scs_pkg::scs_bus_t bus;
  scs_pkg::scs_meas_t meas;
  scs_pkg::scs_stage_t sw, eo;
  int len, n, miscompares = 0, total_checks = 0;
  scs_switch_out #(.MS_CYCLES(4)) dut (.CLOCK_I(clk), .RESET_I(rst),
    .BUS_I(bus), .RDATA_O(rdata), .MEAS_I(meas), .KEY_INC_I(inc),
    .KEY_DEC_I(dec), .KEY_SEL_I(ksel), .IN_PIN_I(pins), .ERROR_I(err),
    .SW_OUT_O(sw), .ERR_OUT_O(eo), .LIGHT_OFF_O(light),
    .IMPULSE_NOTE_O(note));
  scs_load_model load (.clk_i(clk), .stage_i(sw), .on_o(on), .len_o(len));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ----------------------------------------
  // Bus and link tasks
  // ----------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  task automatic idle(input int k);
    repeat (k) @(posedge clk);
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask : rd
  task automatic chkrd(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(v, e)
  endtask : chkrd
  task automatic smp(input int ch, input logic [9:0] val);
    meas <= '{1'b1, 3'(ch), val};
    @(posedge clk);
    meas.valid <= 1'b0;
    @(posedge clk);
  endtask : smp
  // Bounded wait for the load level; n holds the cycles taken
  task automatic waitfor(input logic lvl, input int lim);
    n = 0;
    while (on !== lvl) begin
      @(posedge clk);
      n++;
      if (n > lim) begin
        miscompares++;
        final_report();
      end
    end
  endtask : waitfor
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_thr;
    chkrd(scs_pkg::A_WIN, 32'h20);
    chkrd(8'h3c, 32'h0);
    wr(scs_pkg::A_WIN, 32'h80);
    wr(scs_pkg::A_CMD, 32'h1);
    for (int i = 0; i < 8; i++) smp(i, 10'h064);
    wr(scs_pkg::A_SEL, 32'h0);
    chkrd(scs_pkg::A_HON, 32'he4);
    chkrd(scs_pkg::A_LON, 32'hffffffe4);
    chkrd(scs_pkg::A_HOFF, 32'h104);
    chkrd(scs_pkg::A_LOFF, 32'hffffffc4);
    wr(scs_pkg::A_HOFF, 32'h0);
    wr(scs_pkg::A_HON, 32'hc8);
    chkrd(scs_pkg::A_HOFF, 32'he8);
    wr(scs_pkg::A_SEL, 32'h1);
    chkrd(scs_pkg::A_HON, 32'he4);
    wr(scs_pkg::A_SEL, 32'h5);
    wr(scs_pkg::A_ATHR, 32'h155);
    chkrd(scs_pkg::A_ATHR, 32'h155);
    wr(scs_pkg::A_SEL, 32'h6);
    chkrd(scs_pkg::A_ATHR, 32'h0);
    for (int i = 0; i < 8; i++) smp(i, 10'h064);
    waitfor(1'b1, 40);
    smp(0, 10'h3ff);
    waitfor(1'b0, 40);
    wr(scs_pkg::A_CTRL, 32'ha1);
    chkrd(scs_pkg::A_CTRL, 32'ha1);
    wr(scs_pkg::A_CMD, 32'h1);
    smp(0, 10'h064);
    wr(scs_pkg::A_SEL, 32'h5);
    chkrd(scs_pkg::A_ATHR, 32'h64);
    smp(0, 10'h064);
    waitfor(1'b1, 40);
    smp(0, 10'h3ff);
    waitfor(1'b0, 40);
    wr(scs_pkg::A_CTRL, 32'h0);
    $display("thresholds done");
  endtask : t_thr
  task automatic t_pulse;
    wr(scs_pkg::A_PULSE, 32'h3);
    wr(scs_pkg::A_OFFD, 32'h5);
    idle(2);
    `CHK(note, 1'b1)
    chkrd(scs_pkg::A_OFFD, 32'h0);
    wr(scs_pkg::A_CMD, 32'h2);
    idle(2);
    `CHK(note, 1'b0)
    wr(scs_pkg::A_OND, 32'h2);
    smp(0, 10'h064);
    waitfor(1'b1, 40);
    `CHK(n >= 2 && n <= 14, 1'b1)
    waitfor(1'b0, 40);
    idle(1);
    `CHK(len > 8 && len <= 16, 1'b1)
    idle(40);
    `CHK(on, 1'b0)
    smp(0, 10'h3ff);
    wr(scs_pkg::A_OND, 32'h0);
    $display("pulse done");
  endtask : t_pulse
  task automatic t_offd;
    wr(scs_pkg::A_PULSE, 32'h0);
    wr(scs_pkg::A_OFFD, 32'h5);
    smp(0, 10'h064);
    waitfor(1'b1, 40);
    smp(0, 10'h3ff);
    waitfor(1'b0, 60);
    `CHK(n >= 14 && n <= 26, 1'b1)
    $display("off-delay done");
  endtask : t_offd
  task automatic t_pins;
    wr(scs_pkg::A_CTRL, 32'h2);
    waitfor(1'b1, 10);
    `CHK(sw, 2'b01)
    wr(scs_pkg::A_CTRL, 32'h6);
    idle(3);
    `CHK(sw, 2'b10)
    wr(scs_pkg::A_CTRL, 32'h0);
    waitfor(1'b0, 30);
    err <= 1'b1;
    wr(scs_pkg::A_CTRL, 32'h10);
    idle(2);
    `CHK(eo, 2'b10)
    wr(scs_pkg::A_CTRL, 32'h18);
    idle(2);
    `CHK(eo, 2'b00)
    err <= 1'b0;
    idle(3);
    `CHK(eo, 2'b10)
    wr(scs_pkg::A_CTRL, 32'h0);
    $display("output pins done");
  endtask : t_pins
  task automatic t_in;
    wr(scs_pkg::A_INCFG, 32'h5);
    pins <= 3'b001;
    idle(8);
    `CHK(light, 1'b1)
    pins <= 3'b000;
    idle(8);
    `CHK(light, 1'b0)
    wr(scs_pkg::A_INCFG, 32'h1);
    idle(8);
    `CHK(light, 1'b1)
    wr(scs_pkg::A_INCFG, 32'h30);
    smp(0, 10'h064);
    idle(20);
    `CHK(on, 1'b0)
    pins <= 3'b010;
    waitfor(1'b1, 30);
    smp(0, 10'h3ff);
    pins <= 3'b000;
    waitfor(1'b0, 60);
    wr(scs_pkg::A_INCFG, 32'h0);
    $display("inputs done");
  endtask : t_in
  task automatic t_keys;
    wr(scs_pkg::A_OFFD, 32'h0);
    inc <= 1'b1;
    idle(8400);
    inc <= 1'b0;
    idle(2);
    rd(scs_pkg::A_OFFD);
    `CHK(v > 32'd100 && v <= 32'd10000, 1'b1)
    wr(scs_pkg::A_OFFD, 32'h2710);
    inc <= 1'b1;
    idle(2);
    inc <= 1'b0;
    idle(2);
    chkrd(scs_pkg::A_OFFD, 32'h2710);
    wr(scs_pkg::A_OFFD, 32'h0);
    dec <= 1'b1;
    idle(2);
    dec <= 1'b0;
    idle(2);
    chkrd(scs_pkg::A_OFFD, 32'h0);
    ksel <= 1'b1;
    inc <= 1'b1;
    idle(2);
    inc <= 1'b0;
    idle(2);
    chkrd(scs_pkg::A_PULSE, 32'h1);
    ksel <= 1'b0;
    inc <= 1'b1;
    idle(2);
    inc <= 1'b0;
    idle(2);
    `CHK(note, 1'b1)
    chkrd(scs_pkg::A_OFFD, 32'h0);
    wr(scs_pkg::A_PULSE, 32'h0);
    $display("keys done");
  endtask : t_keys
  initial begin
    rst = 1'b1;
    bus = '0;
    meas = '0;
    {inc, dec, ksel, err} = 4'h0;
    pins = 3'b000;
    idle(4);
    rst <= 1'b0;
    idle(1);
    t_thr();
    t_pulse();
    t_offd();
    t_pins();
    t_in();
    t_keys();
    final_report();
  end
endmodule : scs_switch_out_bench
